// ==== core/css_consts.vh ====
// Behaviour
// - Wait for a stable device clock after hardware reset before configuring.
// - Write software reset as 1, then wait at least 1 us.
// - Link enable written 0 halts the link before link settings change.
// - Calibration enable written 0 halts calibration before its settings change.
// - Program link mode while both state machines are halted.
// - Multiframe length field carries frames per multiframe minus one.
// - Sync source control picks single-ended sync or differential timestamp inputs.
// - Set calibration mode and offset calibration before enabling calibration.
// - Calibration enable written 1 after calibration options are set.
// - After calibration is enabled, set overrange indication enable.
// - Link enable written 1 only after all configuration is complete.
// - Calibration trigger written 0 then 1 as the last step.
`ifndef CSS_CONSTS_VH
`define CSS_CONSTS_VH

// ----------------------------------------
// Register offsets on the AXI4-Lite side
// ----------------------------------------
`define CSS_OFF_CTRL 8'h00
`define CSS_OFF_CFG 8'h04
`define CSS_OFF_STATUS 8'h08
`define CSS_WORD_MASK 8'hfc

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CSS_CTRL_START 0
`define CSS_CTRL_RECAL 1
`define CSS_CFG_MODE_LO 0
`define CSS_CFG_MODE_HI 4
`define CSS_CFG_FRAMES_LO 8
`define CSS_CFG_FRAMES_HI 15
`define CSS_CFG_SYNC_SEL 16
`define CSS_CFG_CAL_BG 17
`define CSS_CFG_CAL_OFS 18
`define CSS_CFG_OVERRANGE_INDICATION_ENABLE 19
`define CSS_ST_BUSY 0
`define CSS_ST_DONE 1
`define CSS_ST_CLK_OK 2
`define CSS_ST_STEP_LO 8
`define CSS_ST_STEP_HI 12

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CSS_RST_MODE 5'h01
`define CSS_RST_FRAMES 8'h20
`define CSS_RST_FLAGS 1'b0

// ----------------------------------------
// Device control selectors
// ----------------------------------------
`define CSS_SEL_SOFT_RESET 4'h0
`define CSS_SEL_LINK_ENABLE 4'h1
`define CSS_SEL_CAL_ENABLE 4'h2
`define CSS_SEL_LINK_MODE 4'h3
`define CSS_SEL_MULTIFRAME 4'h4
`define CSS_SEL_SYNC_SRC 4'h5
`define CSS_SEL_CAL_OPTIONS 4'h6
`define CSS_SEL_OVERRANGE 4'h7
`define CSS_SEL_CAL_TRIGGER 4'h8

// ----------------------------------------
// Timing
// ----------------------------------------
`define CSS_CLK_MHZ 100
`define CSS_SWRST_WAIT_NS 1000
// Counts are sized to the 16-bit timer load; 1000 ns at 100 MHz is 100 cycles.
`define CSS_SWRST_WAIT_CYC 16'h0064
`define CSS_HWRST_HOLD_CYC 16'h0010

`endif

// ==== core/css_host.v ====
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`include "css_consts.vh"

module css_host (
  input wire mclk_i,
  input wire srst_i,
  input wire [7:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [7:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire dev_clk_stable_i,
  input wire dev_wr_ack_i,
  output reg dev_reset_o,
  output reg dev_wr_req_o,
  output reg [3:0] dev_wr_sel_o,
  output reg [7:0] dev_wr_data_o
);

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  localparam [4:0] S_IDLE = 5'd0;
  localparam [4:0] S_HWRST = 5'd1;
  localparam [4:0] S_CLKWAIT = 5'd2;
  localparam [4:0] S_SWRST = 5'd3;
  localparam [4:0] S_SWWAIT = 5'd4;
  localparam [4:0] S_LINKOFF = 5'd5;
  localparam [4:0] S_CALOFF = 5'd6;
  localparam [4:0] S_MODE = 5'd7;
  localparam [4:0] S_FRAMES = 5'd8;
  localparam [4:0] S_SYNC = 5'd9;
  localparam [4:0] S_CALCFG = 5'd10;
  localparam [4:0] S_CALON = 5'd11;
  localparam [4:0] S_OVR = 5'd12;
  localparam [4:0] S_LINKON = 5'd13;
  localparam [4:0] S_TRIG0 = 5'd14;
  localparam [4:0] S_TRIG1 = 5'd15;
  localparam [4:0] S_DONE = 5'd16;

  localparam [1:0] P_IDLE = 2'd0;
  localparam [1:0] P_REQ = 2'd1;
  localparam [1:0] P_REL = 2'd2;

  localparam [1:0] RESP_OKAY = 2'b00;
  localparam [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg clk_s1_q;
  reg clk_s2_q;
  reg ack_s1_q;
  reg ack_s2_q;
  reg [4:0] state_q;
  reg [4:0] state_d;
  reg [1:0] phase_q;
  reg done_q;
  reg start_q;
  reg recal_q;
  reg [4:0] mode_q;
  reg [7:0] frames_q;
  reg sync_sel_q;
  reg cal_bg_q;
  reg cal_ofs_q;
  reg overrange_indication_enable_q;
  reg aw_have_q;
  reg [7:0] aw_addr_q;
  reg w_have_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg [3:0] sel_d;
  reg [7:0] data_d;
  reg [7:0] frames_m1;
  reg tmr_start;
  reg [15:0] tmr_load;
  wire tmr_done;
  wire is_write_state;
  wire step_done;
  wire busy;
  wire wr_fire;
  wire [31:0] status_word;
  wire [31:0] cfg_word;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always @(posedge mclk_i) begin
    if (srst_i) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      clk_s1_q <= dev_clk_stable_i;
      clk_s2_q <= clk_s1_q;
      ack_s1_q <= dev_wr_ack_i;
      ack_s2_q <= ack_s1_q;
    end
  end

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  assign s_axi_awready_o = !aw_have_q && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_have_q && !s_axi_bvalid_o;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid_o;
  assign busy = (state_q != S_IDLE) && (state_q != S_DONE);

  always @(posedge mclk_i) begin
    if (srst_i) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        if (((aw_addr_q & `CSS_WORD_MASK) == `CSS_OFF_CTRL)
            || ((aw_addr_q & `CSS_WORD_MASK) == `CSS_OFF_CFG)
            || ((aw_addr_q & `CSS_WORD_MASK) == `CSS_OFF_STATUS)) begin
          s_axi_bresp_o <= RESP_OKAY;
        end else begin
          s_axi_bresp_o <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Own registers
  // ----------------------------------------
  // Settings are frozen while a sequence runs so that every step sends
  // values from one consistent snapshot.
  always @(posedge mclk_i) begin
    if (srst_i) begin
      start_q <= 1'b0;
      recal_q <= 1'b0;
      mode_q <= `CSS_RST_MODE;
      frames_q <= `CSS_RST_FRAMES;
      sync_sel_q <= `CSS_RST_FLAGS;
      cal_bg_q <= `CSS_RST_FLAGS;
      cal_ofs_q <= `CSS_RST_FLAGS;
      overrange_indication_enable_q <= `CSS_RST_FLAGS;
    end else begin
      start_q <= 1'b0;
      recal_q <= 1'b0;
      if (wr_fire && ((aw_addr_q & `CSS_WORD_MASK) == `CSS_OFF_CTRL) && w_strb_q[0]) begin
        start_q <= w_data_q[`CSS_CTRL_START];
        recal_q <= w_data_q[`CSS_CTRL_RECAL];
      end else if (wr_fire && ((aw_addr_q & `CSS_WORD_MASK) == `CSS_OFF_CFG) && !busy) begin
        if (w_strb_q[0]) begin
          mode_q <= w_data_q[`CSS_CFG_MODE_HI:`CSS_CFG_MODE_LO];
        end
        if (w_strb_q[1]) begin
          frames_q <= w_data_q[`CSS_CFG_FRAMES_HI:`CSS_CFG_FRAMES_LO];
        end
        if (w_strb_q[2]) begin
          sync_sel_q <= w_data_q[`CSS_CFG_SYNC_SEL];
          cal_bg_q <= w_data_q[`CSS_CFG_CAL_BG];
          cal_ofs_q <= w_data_q[`CSS_CFG_CAL_OFS];
          overrange_indication_enable_q <= w_data_q[`CSS_CFG_OVERRANGE_INDICATION_ENABLE];
        end
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign cfg_word = {12'h000, overrange_indication_enable_q, cal_ofs_q, cal_bg_q, sync_sel_q, frames_q, 3'h0, mode_q};
  assign status_word = {19'h00000, state_q, 5'h00, clk_s2_q, done_q, busy};

  always @(posedge mclk_i) begin
    if (srst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= RESP_OKAY;
      if ((s_axi_araddr_i & `CSS_WORD_MASK) == `CSS_OFF_CTRL) begin
        s_axi_rdata_o <= 32'h0000_0000;
      end else if ((s_axi_araddr_i & `CSS_WORD_MASK) == `CSS_OFF_CFG) begin
        s_axi_rdata_o <= cfg_word;
      end else if ((s_axi_araddr_i & `CSS_WORD_MASK) == `CSS_OFF_STATUS) begin
        s_axi_rdata_o <= status_word;
      end else begin
        s_axi_rdata_o <= 32'h0000_0000;
        s_axi_rresp_o <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // Step contents
  // ----------------------------------------
  always @* begin
    {sel_d, data_d} = {`CSS_SEL_SOFT_RESET, 8'h00};
    frames_m1 = (frames_q == 8'h00) ? 8'h00 : frames_q - 8'h01;
    case (state_q)
      S_SWRST: {sel_d, data_d} = {`CSS_SEL_SOFT_RESET, 8'h01};
      S_LINKOFF: {sel_d, data_d} = {`CSS_SEL_LINK_ENABLE, 8'h00};
      S_CALOFF: {sel_d, data_d} = {`CSS_SEL_CAL_ENABLE, 8'h00};
      S_MODE: {sel_d, data_d} = {`CSS_SEL_LINK_MODE, 3'h0, mode_q};
      S_FRAMES: {sel_d, data_d} = {`CSS_SEL_MULTIFRAME, frames_m1};
      S_SYNC: {sel_d, data_d} = {`CSS_SEL_SYNC_SRC, 7'h00, sync_sel_q};
      S_CALCFG: {sel_d, data_d} = {`CSS_SEL_CAL_OPTIONS, 6'h00, cal_ofs_q, cal_bg_q};
      S_CALON: {sel_d, data_d} = {`CSS_SEL_CAL_ENABLE, 8'h01};
      S_OVR: {sel_d, data_d} = {`CSS_SEL_OVERRANGE, 7'h00, overrange_indication_enable_q};
      S_LINKON: {sel_d, data_d} = {`CSS_SEL_LINK_ENABLE, 8'h01};
      S_TRIG0: {sel_d, data_d} = {`CSS_SEL_CAL_TRIGGER, 8'h00};
      S_TRIG1: {sel_d, data_d} = {`CSS_SEL_CAL_TRIGGER, 8'h01};
      default: {sel_d, data_d} = {`CSS_SEL_SOFT_RESET, 8'h00};
    endcase
  end

  assign is_write_state = (state_q == S_SWRST) || ((state_q >= S_LINKOFF) && (state_q <= S_TRIG1));
  // A step ends only when the device has dropped its ack again.
  assign step_done = (phase_q == P_REL) && !ack_s2_q;

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    tmr_start = 1'b0;
    tmr_load = 16'h0000;
    case (state_q)
      S_IDLE, S_DONE: begin
        if (start_q) begin
          state_d = S_HWRST;
          tmr_start = 1'b1;
          tmr_load = `CSS_HWRST_HOLD_CYC;
        end else if (recal_q && (state_q == S_DONE)) begin
          state_d = S_TRIG0;
        end
      end
      S_HWRST: begin
        if (tmr_done) begin
          state_d = S_CLKWAIT;
        end
      end
      S_CLKWAIT: begin
        if (clk_s2_q) begin
          state_d = S_SWRST;
        end
      end
      S_SWRST: begin
        if (step_done) begin
          state_d = S_SWWAIT;
          tmr_start = 1'b1;
          tmr_load = `CSS_SWRST_WAIT_CYC;
        end
      end
      S_SWWAIT: begin
        if (tmr_done) begin
          state_d = S_LINKOFF;
        end
      end
      default: begin
        if (is_write_state && step_done) begin
          state_d = state_q + 5'd1;
        end
      end
    endcase
  end

  css_timer u_timer (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .start_i(tmr_start),
    .load_i(tmr_load),
    .done_o(tmr_done)
  );

  // ----------------------------------------
  // Sequencer and device write port
  // ----------------------------------------
  // The request is a four-phase handshake so that it survives the
  // synchroniser delay on the ack, whatever clock the device answers on.
  always @(posedge mclk_i) begin
    if (srst_i) begin
      state_q <= S_IDLE;
      phase_q <= P_IDLE;
      done_q <= 1'b0;
      dev_reset_o <= 1'b0;
      dev_wr_req_o <= 1'b0;
      dev_wr_sel_o <= 4'h0;
      dev_wr_data_o <= 8'h00;
    end else begin
      state_q <= state_d;
      dev_reset_o <= (state_d == S_HWRST);
      done_q <= (state_d == S_DONE) || (done_q && (state_d == S_IDLE));
      case (phase_q)
        P_IDLE: begin
          if (is_write_state && !ack_s2_q) begin
            phase_q <= P_REQ;
            dev_wr_req_o <= 1'b1;
            dev_wr_sel_o <= sel_d;
            dev_wr_data_o <= data_d;
          end
        end
        P_REQ: begin
          if (ack_s2_q) begin
            phase_q <= P_REL;
            dev_wr_req_o <= 1'b0;
          end
        end
        P_REL: begin
          if (!ack_s2_q) begin
            phase_q <= P_IDLE;
          end
        end
        default: phase_q <= P_IDLE;
      endcase
    end
  end

endmodule // css_host

// ==== core/css_timer.v ====
`timescale 1ns/100ps
`include "css_consts.vh"

module css_timer (
  input wire mclk_i,
  input wire srst_i,
  input wire start_i,
  input wire [15:0] load_i,
  output wire done_o
);

  reg [15:0] cnt_q;
  reg run_q;

  // ----------------------------------------
  // Down counter
  // ----------------------------------------
  // A zero load still waits one cycle so no wait is ever skipped.
  always @(posedge mclk_i) begin
    if (srst_i) begin
      cnt_q <= 16'h0000;
      run_q <= 1'b0;
    end else if (start_i) begin
      cnt_q <= (load_i == 16'h0000) ? 16'h0000 : load_i - 16'h0001;
      run_q <= 1'b1;
    end else if (run_q) begin
      if (cnt_q == 16'h0000) begin
        run_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end

  assign done_o = run_q && (cnt_q == 16'h0000) && !start_i;

endmodule // css_timer

// ==== verification/css_dev_model.sv ====
`timescale 1ns/100ps
module css_dev_model #(
  parameter int STABLE_DLY = 20
) (
  input wire mclk_i,
  input wire dev_reset_i,
  input wire slow_i,
  input wire req_i,
  input wire [3:0] sel_i,
  input wire [7:0] data_i,
  output logic ack_o,
  output logic clk_stable_o,
  output logic dual_o
);
  logic [11:0] log_q [0:255];
  integer n_wr = 0, n_err = 0, n_cal = 0, cyc = 0, swr_cyc = -1000, wait_c = 0, dly = 0;
  logic link_en = 1'b1, cal_en = 1'b1, trig = 1'b0, sync_sel = 1'b0, ovr = 1'b0, sync_wait = 1'b0;
  logic [4:0] mode = 5'h01;
  logic [7:0] km1 = 8'h1f;
  logic [1:0] cal_opt = 2'b00;
  assign dual_o = (mode == 5'h03);
  initial begin
    ack_o = 1'b0;
    clk_stable_o = 1'b0;
  end
  always @(posedge mclk_i) begin
    cyc = cyc + 1;
    if (dev_reset_i) begin
      wait_c = 0;
      clk_stable_o <= 1'b0;
      link_en = 1'b1;
      cal_en = 1'b1;
      trig = 1'b0;
      mode = 5'h01;
    end else if (!clk_stable_o) begin
      wait_c = wait_c + 1;
      clk_stable_o <= (wait_c >= STABLE_DLY);
    end
    if (!req_i) begin
      ack_o <= 1'b0;
      dly = slow_i ? 6 : 0;
    end else if (!ack_o && dly > 0) begin
      dly = dly - 1;
    end else if (!ack_o) begin
      ack_o <= 1'b1;
      log_q[n_wr] = {sel_i, data_i};
      n_wr = n_wr + 1;
      if (!clk_stable_o || cyc - swr_cyc < 100) n_err += 1;
      case (sel_i)
        4'h0: if (data_i[0]) swr_cyc = cyc;
        4'h1: begin
          if (data_i[0] && !cal_en) n_err += 1;
          link_en = data_i[0];
          // restarted link idles until the receiver requests sync
          sync_wait = data_i[0];
        end
        4'h2: cal_en = data_i[0];
        4'h3: if (link_en || cal_en) n_err += 1; else mode = data_i[4:0];
        4'h4: if (link_en) n_err += 1; else km1 = data_i;
        4'h5: if (link_en) n_err += 1; else sync_sel = data_i[0];
        4'h6: if (cal_en) n_err += 1; else cal_opt = data_i[1:0];
        4'h7: if (!cal_en) n_err += 1; else ovr = data_i[0];
        default: begin
          if (data_i[0] && !trig) n_cal += 1;
          trig = data_i[0];
        end
      endcase
    end
  end
endmodule // css_dev_model

// ==== verification/css_host_chk.sv ====
`timescale 1ns/100ps
module css_host_chk (
  input wire mclk_i,
  input wire srst_i,
  input wire s_axi_awvalid_i,
  input wire s_axi_awready_o,
  input wire s_axi_wvalid_i,
  input wire s_axi_wready_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire dev_wr_ack_i,
  input wire dev_reset_o,
  input wire dev_wr_req_o,
  input wire [3:0] dev_wr_sel_o,
  input wire [7:0] dev_wr_data_o
);
  // ----------------------------------------
  // Cycles since the last soft reset request
  // ----------------------------------------
  reg [7:0] gap_q;
  always @(posedge mclk_i) begin
    if (srst_i) gap_q <= 8'h00;
    else if (dev_wr_req_o && dev_wr_sel_o == 4'h0) gap_q <= 8'h01;
    else if (gap_q != 8'h00 && gap_q != 8'hff) gap_q <= gap_q + 8'h01;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  req_stable_a: assert property (dev_wr_req_o && $past(dev_wr_req_o) |->
    $stable(dev_wr_sel_o) && $stable(dev_wr_data_o)) else $error("device write changed");
  req_after_ack_a: assert property ($rose(dev_wr_req_o) |-> !dev_wr_ack_i && !$past(dev_wr_ack_i, 2))
    else $error("request raised before ack low");
  req_release_a: assert property (dev_wr_req_o && dev_wr_ack_i |-> ##[1:4] !dev_wr_req_o)
    else $error("request not released");
  swrst_wait_a: assert property ($rose(dev_wr_req_o) && gap_q != 8'h00 |-> gap_q >= 8'd100)
    else $error("soft reset wait too short");
  hw_reset_a: assert property ($rose(dev_reset_o) |-> ##15 dev_reset_o ##1 !dev_reset_o)
    else $error("device reset length wrong");
  reset_quiet_a: assert property (dev_reset_o |-> !dev_wr_req_o)
    else $error("write during device reset");
  wr_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
    s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write response late");
  b_busy_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken during response");
  b_drop_a: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("bvalid not dropped");
  rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o ##0
    !s_axi_arready_o) else $error("read response wrong");
  r_drop_a: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("rvalid not dropped");
endmodule // css_host_chk
bind css_host css_host_chk u_chk (.mclk_i(mclk_i), .srst_i(srst_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .dev_wr_ack_i(dev_wr_ack_i), .dev_reset_o(dev_reset_o), .dev_wr_req_o(dev_wr_req_o),
  .dev_wr_sel_o(dev_wr_sel_o), .dev_wr_data_o(dev_wr_data_o));

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  reg mclk, srst, awv, wv, arv, bready, rready, slow;
  reg [7:0] awaddr, araddr;
  reg [31:0] wdata, rd;
  reg [3:0] wstrb;
  reg [1:0] resp;
  reg [32:0] rows [0:3];
  wire awready, wready, bvalid, arready, rvalid, ack, stable, dev_rst, req, dual;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] sel;
  wire [7:0] wd;
  integer n_fail, n_tests, cyc, i, j, base;
  css_host dut (.mclk_i(mclk), .srst_i(srst), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wv), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .dev_clk_stable_i(stable), .dev_wr_ack_i(ack),
    .dev_reset_o(dev_rst), .dev_wr_req_o(req), .dev_wr_sel_o(sel), .dev_wr_data_o(wd));
  css_dev_model dev (.mclk_i(mclk), .dev_reset_i(dev_rst), .slow_i(slow), .req_i(req),
    .sel_i(sel), .data_i(wd), .ack_o(ack), .clk_stable_o(stable), .dual_o(dual));
  // ----------------------------------------
  // Bus tasks and checks
  // ----------------------------------------
  task chk(input [8*12-1:0] nm, input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task axw(input [7:0] a, input [31:0] d, input [3:0] s);
    reg ta, tw;
    begin
      @(posedge mclk);
      {awaddr, wdata, wstrb, awv, wv, bready} <= {a, d, s, 3'b111};
      ta = 1'b0;
      tw = 1'b0;
      while (!(ta && tw)) begin
        @(negedge mclk);
        ta = ta || (awv && awready);
        tw = tw || (wv && wready);
        @(posedge mclk);
        if (ta) awv <= 1'b0;
        if (tw) wv <= 1'b0;
      end
      @(negedge mclk);
      while (!bvalid) @(negedge mclk);
      resp = bresp;
      @(posedge mclk);
      bready <= 1'b0;
    end
  endtask
  task axr(input [7:0] a);
    begin
      @(posedge mclk);
      {araddr, arv, rready} <= {a, 2'b11};
      @(negedge mclk);
      while (!arready) @(negedge mclk);
      @(posedge mclk);
      arv <= 1'b0;
      @(negedge mclk);
      while (!rvalid) @(negedge mclk);
      {rd, resp} = {rdata, rresp};
      @(posedge mclk);
      rready <= 1'b0;
    end
  endtask
  task run_wait;
    begin
      axr(8'h08);
      while (rd[1:0] !== 2'b10) axr(8'h08);
    end
  endtask
  function [11:0] exp_w(input [31:0] c, input integer k);
    reg [7:0] km1;
    begin
      km1 = (c[15:8] == 8'h00) ? 8'h00 : c[15:8] - 8'h01;
      case (k)
        0: exp_w = 12'h001;
        1: exp_w = 12'h100;
        2: exp_w = 12'h200;
        3: exp_w = {4'h3, 3'h0, c[4:0]};
        4: exp_w = {4'h4, km1};
        5: exp_w = {4'h5, 7'h00, c[16]};
        6: exp_w = {4'h6, 6'h00, c[18], c[17]};
        7: exp_w = 12'h201;
        8: exp_w = {4'h7, 7'h00, c[19]};
        9: exp_w = 12'h101;
        10: exp_w = 12'h800;
        default: exp_w = 12'h801;
      endcase
    end
  endfunction
  task seq_chk(input [31:0] c, input integer first);
    begin
      chk("write count", 12 - first, dev.n_wr - base);
      for (j = first; j < 12; j = j + 1)
        chk("device wr", exp_w(c, j), dev.log_q[base + j - first]);
      chk("order err", 0, dev.n_err);
    end
  endtask
  task give_verdict;
    begin
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      give_verdict;
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {srst, awv, wv, arv, bready, rready, slow} = 7'b1000000;
    {awaddr, araddr, wdata, wstrb} = 0;
    {n_fail, n_tests, cyc, base} = 0;
    rows[0] = {1'b0, 32'h00002001};
    rows[1] = {1'b1, 32'h000f0103};
    rows[2] = {1'b0, 32'h00020001};
    rows[3] = {1'b1, 32'h0009ff03};
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    axr(8'h04);
    chk("cfg reset", 32'h00002001, rd);
    axr(8'h08);
    chk("status rst", 2'b00, rd[1:0]);
    for (i = 0; i < 4; i = i + 1) begin
      slow <= i[0];
      axw(8'h04, rows[i][31:0], 4'h7);
      base = dev.n_wr;
      axw(8'h00, 32'h1, 4'h1);
      run_wait;
      chk("clk ok", 1, rd[2]);
      seq_chk(rows[i][31:0], 0);
      chk("link sync", 1, dev.sync_wait);
      chk("dual mode", rows[i][32], dual);
      axr(8'h04);
      chk("cfg read", rows[i][31:0], rd & 32'h000fff1f);
    end
    base = dev.n_wr;
    i = dev.n_cal;
    axw(8'h00, 32'h2, 4'h1);
    run_wait;
    seq_chk(rows[3][31:0], 10);
    chk("cal runs", i + 1, dev.n_cal);
    axw(8'h00, 32'h1, 4'h1);
    base = dev.n_wr;
    axw(8'h04, rows[1][31:0], 4'h7);
    chk("busy resp", 2'b00, resp);
    run_wait;
    seq_chk(rows[3][31:0], 0);
    axw(8'h10, 32'h1, 4'h1);
    chk("unmap wresp", 2'b10, resp);
    axr(8'h10);
    chk("unmap rresp", {30'h0, 2'b10}, {30'h0, resp});
    chk("unmap rdata", 32'h0, rd);
    axw(8'h00, 32'h1, 4'h1);
    repeat (60) @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
    chk("rst outputs", 2'b00, {dev_rst, req});
    axr(8'h04);
    chk("cfg reset", 32'h00002001, rd);
    give_verdict;
  end
endmodule // tb_top
